// [rtl/insn_exec_pkg.sv]
// Constants for the file-register add, mask and bit instruction executor.
// Assumes a 14-bit instruction word and an 8-bit data path.
package insn_exec_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    // Field positions
    localparam int ADDR_LSB = 0;
    localparam int DEST_POS = 7;
    localparam int BIT_LSB  = 7;
    localparam int BIT_W    = 3;
    localparam int OPC_LSB  = 8;
    localparam int BOP_LSB  = 10;
    // Opcode patterns
    localparam logic [5:0] OPC_SUM  = 6'h07;
    localparam logic [5:0] OPC_MASK = 6'h05;
    localparam logic [3:0] BOP_CLR  = 4'h4;
    localparam logic [3:0] BOP_SET  = 4'h5;
    localparam logic [3:0] BOP_TST  = 4'h6;
    // Destination select encodings
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    // Skip flush lasts one extra cycle
    localparam int SKIP_CYCLES = 2;
endpackage

// [rtl/insn_field_split.sv]
// Splits a 14-bit instruction word into its operand fields.
// Assumes a word from logic on the same clock.
`timescale 1ns/1ns
module insn_field_split (
    input  wire logic [13:0] insnWord,
    output logic      [6:0]  fileAddr,
    output logic             destSel,
    output logic      [2:0]  bitIdx,
    output logic      [5:0]  byteOpc,
    output logic      [3:0]  bitOpc
);
    // Field extraction
    assign fileAddr = insnWord[insn_exec_pkg::ADDR_LSB +: insn_exec_pkg::ADDR_W];
    assign destSel  = insnWord[insn_exec_pkg::DEST_POS];
    assign bitIdx   = insnWord[insn_exec_pkg::BIT_LSB +: insn_exec_pkg::BIT_W];
    assign byteOpc  = insnWord[insn_exec_pkg::OPC_LSB +: 6];
    assign bitOpc   = insnWord[insn_exec_pkg::BOP_LSB +: 4];
endmodule // insn_field_split

// [rtl/add_and_bit_ops_decode.sv]
// Executes sum, mask and bit clear/set/test instructions for one cycle each, two for a bit test that skips.
// Assumes an outside fetch stage and register file; carry, nibble and zero flags are held here;
// the file operand is read combinationally from fileRdData for insnWord.
`timescale 1ns/1ns
module add_and_bit_ops_decode (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        insnValid,
    input  wire logic [13:0] insnWord,
    input  wire logic [7:0]  fileRdData,
    output logic      [6:0]  fileAddr_r,
    output logic      [7:0]  fileWrData_r,
    output logic             fileWrEn_r,
    output logic      [7:0]  accOut_r,
    output logic             carryFlag_r,
    output logic             nibble_overflow_bit_r,
    output logic             zeroFlag_r,
    output logic             flushFetch_r,
    output logic             idleExec_r,
    output logic             insnKnown_r
);
    // State of the skip sequencer
    typedef enum logic [1:0] {
        RUN  = 2'b01,
        IDLE = 2'b10
    } seq_t;

    logic [6:0] addrF;
    logic       destF;
    logic [2:0] bitF;
    logic [5:0] byteOpc;
    logic [3:0] bitOpc;

    insn_field_split u_split (
        .insnWord (insnWord),
        .fileAddr (addrF),
        .destSel  (destF),
        .bitIdx   (bitF),
        .byteOpc  (byteOpc),
        .bitOpc   (bitOpc)
    );

    seq_t       seq_r, seq_nxt;
    logic [6:0] fileAddr_nxt;
    logic [7:0] fileWrData_nxt;
    logic       fileWrEn_nxt;
    logic [7:0] acc_nxt;
    logic       carry_nxt, nib_nxt, zero_nxt;
    logic       flush_nxt, idle_nxt, known_nxt;

    // Single-bit mask from the bit index
    function automatic logic [7:0] bitMask(input logic [2:0] idx);
        bitMask = 8'h01 << idx;
    endfunction

    logic isSum, isMask, isClr, isSet, isTst;
    logic [8:0] sumFull;
    logic [4:0] nibFull;
    logic [7:0] result;
    logic       skipTaken;

    // Opcode decode
    always_comb begin
        isSum  = (byteOpc == insn_exec_pkg::OPC_SUM);
        isMask = (byteOpc == insn_exec_pkg::OPC_MASK);
        isClr  = (bitOpc == insn_exec_pkg::BOP_CLR);
        isSet  = (bitOpc == insn_exec_pkg::BOP_SET);
        isTst  = (bitOpc == insn_exec_pkg::BOP_TST);
        sumFull = {1'b0, accOut_r} + {1'b0, fileRdData};
        nibFull = {1'b0, accOut_r[3:0]} + {1'b0, fileRdData[3:0]};
        result  = isSum ? sumFull[7:0] : (accOut_r & fileRdData);
        skipTaken = isTst && ((fileRdData & bitMask(bitF)) == 8'h00);
    end

    // Next-state and execute
    always_comb begin
        seq_nxt        = RUN;
        fileAddr_nxt   = addrF;
        fileWrData_nxt = fileWrData_r;
        fileWrEn_nxt   = 1'b0;
        acc_nxt        = accOut_r;
        carry_nxt      = carryFlag_r;
        nib_nxt        = nibble_overflow_bit_r;
        zero_nxt       = zeroFlag_r;
        flush_nxt      = 1'b0;
        idle_nxt       = 1'b0;
        known_nxt      = 1'b0;
        case (seq_r)
            IDLE: begin
                // Fetched word discarded; idle cycle runs in its place
                idle_nxt = 1'b0;
            end
            RUN: begin
                if (insnValid) begin
                    if (isSum || isMask) begin
                        known_nxt = 1'b1;               // done in one edge
                        if (destF == insn_exec_pkg::DEST_FILE) begin
                            fileWrEn_nxt   = 1'b1;
                            fileWrData_nxt = result;
                        end else begin
                            acc_nxt = result;
                        end
                        zero_nxt = (result == 8'h00);
                        if (isSum) begin
                            carry_nxt = sumFull[8];
                            nib_nxt   = nibFull[4];
                        end
                    end else if (isClr || isSet) begin
                        known_nxt      = 1'b1;
                        fileWrEn_nxt   = 1'b1;           // flags kept
                        fileWrData_nxt = isSet ? (fileRdData | bitMask(bitF))
                                               : (fileRdData & ~bitMask(bitF));
                    end else if (isTst) begin
                        known_nxt = 1'b1;
                        if (skipTaken) begin
                            flush_nxt = 1'b1;
                            idle_nxt  = 1'b1;
                            seq_nxt   = IDLE;
                        end
                    end
                end
            end
            default: seq_nxt = RUN;
        endcase
    end

    // Registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seq_r                 <= RUN;
            fileAddr_r            <= 7'h00;
            fileWrData_r          <= 8'h00;
            fileWrEn_r            <= 1'b0;
            accOut_r              <= insn_exec_pkg::ACC_RST;
            carryFlag_r           <= 1'b0;
            nibble_overflow_bit_r <= 1'b0;
            zeroFlag_r            <= 1'b0;
            flushFetch_r          <= 1'b0;
            idleExec_r            <= 1'b0;
            insnKnown_r           <= 1'b0;
        end else begin
            seq_r                 <= seq_nxt;
            fileAddr_r            <= fileAddr_nxt;
            fileWrData_r          <= fileWrData_nxt;
            fileWrEn_r            <= fileWrEn_nxt;
            accOut_r              <= acc_nxt;
            carryFlag_r           <= carry_nxt;
            nibble_overflow_bit_r <= nib_nxt;
            zeroFlag_r            <= zero_nxt;
            flushFetch_r          <= flush_nxt;
            idleExec_r            <= idle_nxt;
            insnKnown_r           <= known_nxt;
        end
    end

    // Checks
    property p_sum_acc;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isSum && !destF)
            |=> (accOut_r == $past(sumFull[7:0]) && carryFlag_r == $past(sumFull[8]));
    endproperty
    a_sum_acc: assert property (p_sum_acc) else $error("sum to accumulator wrong");

    property p_dest_file;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && (isSum || isMask) && destF)
            |=> (fileWrEn_r && accOut_r == $past(accOut_r));
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

    property p_zero;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && (isSum || isMask)) |=> (zeroFlag_r == $past(result == 8'h00));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_nib;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isSum) |=> (nibble_overflow_bit_r == $past(nibFull[4]));
    endproperty
    a_nib: assert property (p_nib) else $error("nibble overflow wrong");

    property p_clr;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isClr)
            |=> (fileWrEn_r && (fileWrData_r & bitMask($past(bitF))) == 8'h00);
    endproperty
    a_clr: assert property (p_clr) else $error("bit clear wrong");

    property p_set;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isSet)
            |=> (fileWrEn_r && (fileWrData_r & bitMask($past(bitF))) != 8'h00);
    endproperty
    a_set: assert property (p_set) else $error("bit set wrong");

    property p_skip;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && skipTaken) |=> (flushFetch_r && idleExec_r) ##1 !flushFetch_r;
    endproperty
    a_skip: assert property (p_skip) else $error("skip flush wrong");

    property p_noskip;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isTst && !skipTaken) |=> !flushFetch_r;
    endproperty
    a_noskip: assert property (p_noskip) else $error("spurious skip");

    property p_flags_kept;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && (isClr || isSet || isTst))
            |=> ($stable(carryFlag_r) && $stable(zeroFlag_r) && $stable(nibble_overflow_bit_r));
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("bit op touched flags");

    property p_mask_carry;
        @(posedge core_clk) disable iff (reset)
        (seq_r == RUN && insnValid && isMask) |=> $stable(carryFlag_r);
    endproperty
    a_mask_carry: assert property (p_mask_carry) else $error("mask touched carry");
endmodule // add_and_bit_ops_decode

// [sim/add_and_bit_ops_decode_tb_top.sv]
// Self-checking bench for the sum, mask and bit instruction executor.
// Drives the ports directly; accumulator and flags are modelled here.
`timescale 1ns/1ns
module add_and_bit_ops_decode_tb_top;
    typedef struct packed {
        logic [7:0] acc;
        logic [2:0] flg;
        logic       we;
        logic [7:0] wd;
        logic [6:0] adr;
        logic       fl;
    } note_t;
    logic        core_clk   = 1'b0;
    logic        reset      = 1'b1;
    logic        insnValid  = 1'b0;
    logic [13:0] insnWord   = 14'h0000;
    logic [7:0]  fileRdData = 8'h00;
    logic [6:0]  fileAddr_r;
    logic [7:0]  fileWrData_r;
    logic        fileWrEn_r;
    logic [7:0]  accOut_r;
    logic        carryFlag_r;
    logic        nibble_overflow_bit_r;
    logic        zeroFlag_r;
    logic        flushFetch_r;
    logic        idleExec_r;
    logic        insnKnown_r;
    note_t       noteQ[$];
    note_t       q;
    logic [7:0]  mAcc = 8'h00;
    logic [2:0]  mFlg = 3'h0;
    logic        skipNext = 1'b0;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          seed = 32'h48EF09C3;
    int          k;
    logic [31:0] rnd;
    // Clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    add_and_bit_ops_decode dut (.core_clk(core_clk), .reset(reset), .insnValid(insnValid),
        .insnWord(insnWord), .fileRdData(fileRdData), .fileAddr_r(fileAddr_r),
        .fileWrData_r(fileWrData_r), .fileWrEn_r(fileWrEn_r), .accOut_r(accOut_r),
        .carryFlag_r(carryFlag_r), .nibble_overflow_bit_r(nibble_overflow_bit_r),
        .zeroFlag_r(zeroFlag_r), .flushFetch_r(flushFetch_r), .idleExec_r(idleExec_r),
        .insnKnown_r(insnKnown_r));
    // Compare and count
    task automatic check(input string nm, input logic [7:0] ex, input logic [7:0] sn);
        num_checks++;
        if (sn !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Issue one word and note the expected outcome from the model
    task automatic exec(input logic [13:0] w, input logic [7:0] f);
        logic [8:0] s;
        logic [7:0] r;
        logic       byteOp;
        logic       known;
        @(posedge core_clk);
        insnValid  <= 1'b1;
        insnWord   <= w;
        fileRdData <= f;
        r = f;
        byteOp = 1'b0;
        known = 1'b1;
        if (skipNext) begin
            skipNext = 1'b0; // Flushed word, no note
            return;
        end
        if (w[13:8] == insn_exec_pkg::OPC_SUM) begin
            s = {1'b0, mAcc} + {1'b0, f};
            r = s[7:0];
            byteOp = 1'b1;
            mFlg = {s[8], ({1'b0, mAcc[3:0]} + {1'b0, f[3:0]}) > 5'h0F, r == 8'h00};
        end else if (w[13:8] == insn_exec_pkg::OPC_MASK) begin
            r = mAcc & f;
            byteOp = 1'b1;
            mFlg[0] = (r == 8'h00);
        end else if (w[13:10] == insn_exec_pkg::BOP_CLR) r[w[9:7]] = 1'b0;
        else if (w[13:10] == insn_exec_pkg::BOP_SET) r[w[9:7]] = 1'b1;
        else if (w[13:10] == insn_exec_pkg::BOP_TST) skipNext = ~f[w[9:7]];
        else known = 1'b0;
        if (byteOp && !w[7]) mAcc = r;
        q = '{mAcc, mFlg, (byteOp & w[7]) | (w[13:11] == 3'h2), r, w[6:0], skipNext};
        if (known) noteQ.push_back(q);
    endtask
    task automatic idle();
        @(posedge core_clk);
        insnValid <= 1'b0;
        skipNext = 1'b0;
    endtask
    // Takes the oldest note whenever a result is reported
    initial begin
        forever begin
            @(negedge core_clk);
            if (insnKnown_r === 1'b1 && noteQ.size() == 0) check("stray", 8'h00, 8'h01);
            else if (insnKnown_r === 1'b1) begin
                q = noteQ.pop_front();
                check("acc", q.acc, accOut_r);
                check("flags", q.flg, {carryFlag_r, nibble_overflow_bit_r, zeroFlag_r});
                check("wrEn", q.we, fileWrEn_r);
                if (q.we) check("wrData", q.wd, fileWrData_r);
                check("addr", q.adr, fileAddr_r);
                check("flush", {q.fl, q.fl}, {flushFetch_r, idleExec_r});
            end else check("quiet", 8'h00, {fileWrEn_r, flushFetch_r});
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        exec({insn_exec_pkg::OPC_SUM, 1'b0, 7'h04}, 8'h17);
        exec({insn_exec_pkg::OPC_SUM, 1'b1, 7'h04}, 8'hC2);
        exec({insn_exec_pkg::OPC_SUM, 1'b1, 7'h7F}, 8'hE9);
        exec({insn_exec_pkg::OPC_MASK, 1'b1, 7'h04}, 8'hC2);
        exec({insn_exec_pkg::BOP_CLR, 3'h7, 7'h11}, 8'hC7);
        exec({insn_exec_pkg::BOP_SET, 3'h7, 7'h11}, 8'h0A);
        exec({insn_exec_pkg::BOP_TST, 3'h1, 7'h22}, 8'hFD);
        exec({insn_exec_pkg::OPC_SUM, 1'b0, 7'h05}, 8'h33);
        exec({insn_exec_pkg::BOP_TST, 3'h1, 7'h22}, 8'h02);
        exec({2'h3, 12'hABC}, 8'h55);
        for (k = 0; k < 600; k++) begin
            rnd = $random(seed);
            case ({$random(seed)} % 7)
                0: exec({insn_exec_pkg::OPC_SUM, rnd[7:0]}, rnd[15:8]);
                1: exec({insn_exec_pkg::OPC_MASK, rnd[7:0]}, rnd[15:8]);
                2: exec({insn_exec_pkg::BOP_CLR, rnd[9:0]}, rnd[17:10]);
                3: exec({insn_exec_pkg::BOP_SET, rnd[9:0]}, rnd[17:10]);
                4: exec({insn_exec_pkg::BOP_TST, rnd[9:0]}, rnd[17:10]);
                5: exec({2'h3, rnd[11:0]}, rnd[19:12]);
                default: idle();
            endcase
        end
        idle();
        reset <= 1'b1;
        @(negedge core_clk);
        check("rstOut", 8'h00, accOut_r | {carryFlag_r, zeroFlag_r, insnKnown_r, flushFetch_r});
        noteQ.delete();
        mAcc = 8'h00;
        mFlg = 3'h0;
        skipNext = 1'b0;
        @(posedge core_clk);
        reset <= 1'b0;
        exec({insn_exec_pkg::OPC_SUM, 1'b0, 7'h01}, 8'h08);
        exec({insn_exec_pkg::OPC_SUM, 1'b0, 7'h01}, 8'h08);
        idle();
        for (k = 0; k < 8 && noteQ.size() > 0; k++) @(posedge core_clk);
        if (noteQ.size() > 0) check("drain", 8'h00, 8'h01);
        wrap_up();
    end
endmodule // add_and_bit_ops_decode_tb_top
